// ---- design/serial_channel_pkg.sv ----
// Shared constants, types and helpers for one serial channel
// Assumes a host driving synchronous read/write strobes on a 3-bit register address
// Operation
// - FIFO control is write-only at offset 2; reads there return identification.
// - Control bit 0 enables both FIFOs; zero returns to single-buffer mode.
// - Any change of the enable bit flushes both FIFOs.
// - Other control bits only take effect when written with enable set.
// - Control bit 1 empties receive FIFO, shift register untouched.
// - Control bit 2 empties transmit FIFO, shift register untouched.
// - Control bit 3 selects ready pin mode 1 while FIFOs enabled.
// - Control bits 4 and 5 are reserved, ignored, written as zero.
// - Control bits 7:6 select the receive interrupt fill level.
// - With FIFOs off, identification bits 7,6,3 and status bit 7 read zero.
// - Interrupt enable holds four source enables; bits 7:4 read zero.
// - Line status reports ready, overrun, parity, framing, break, empties, FIFO error.
// - Divisor select bit maps offsets 0 and 1 onto divisor bytes.
// - Identification bit 0 reads zero while an enabled interrupt is pending.
// - Data bit 0 is first on the line; short words right-justified.
package serial_channel_pkg;

	// ************************************************
	// Register map and fields
	// ************************************************
	localparam logic [2:0] OFF_DATA = 3'h0;
	localparam logic [2:0] OFF_IER  = 3'h1;
	localparam logic [2:0] OFF_IIR  = 3'h2;
	localparam logic [2:0] OFF_LCR  = 3'h3;
	localparam logic [2:0] OFF_MCR  = 3'h4;
	localparam logic [2:0] OFF_LSR  = 3'h5;
	localparam logic [2:0] OFF_MSR  = 3'h6;
	localparam logic [2:0] OFF_SCR  = 3'h7;
	localparam int FCR_EN = 0;
	localparam int FCR_RXCLR = 1;
	localparam int FCR_TXCLR = 2;
	localparam int FCR_MODE = 3;
	localparam int FCR_TRIG = 6;
	localparam int LCR_STB = 2;
	localparam int LCR_PEN = 3;
	localparam int LCR_EPS = 4;
	localparam int LCR_STICK = 5;
	localparam int LCR_BRK = 6;
	localparam int LCR_DIVISOR_LATCH_SELECT = 7;
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LS = 2;
	localparam int IER_MS = 3;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_SPARE_OUTPUT = 2;
	localparam int MCR_IRQ_PIN_GATE = 3;
	localparam int MCR_LOOP = 4;
	localparam logic [3:0] IID_NONE = 4'h1;
	localparam logic [3:0] IID_LINE = 4'h6;
	localparam logic [3:0] IID_RXD  = 4'h4;
	localparam logic [3:0] IID_TX_HOLDING_EMPTY_FLAG = 4'h2;
	localparam logic [3:0] IID_MDM  = 4'h0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [4:0] FIFO_FULL = 5'h10;
	localparam logic [4:0] ONE_DEEP = 5'h01;
	localparam logic [4:0] TRIG_L0 = 5'h01;
	localparam logic [4:0] TRIG_L1 = 5'h04;
	localparam logic [4:0] TRIG_L2 = 5'h08;
	localparam logic [4:0] TRIG_L3 = 5'h0E;
	localparam logic [3:0] BASE_WORD = 4'h5;
	localparam logic [3:0] LAST_TICK = 4'hF;
	localparam logic [3:0] HALF_TICK = 4'h7;
	localparam logic [1:0] BUF_DEPTH = 2'h2;

	// ************************************************
	// Types
	// ************************************************
	typedef struct packed {logic rd; logic wr; logic [2:0] addr; logic [7:0] data;} reg_req_t;
	typedef struct packed {logic dcd; logic ri; logic dsr; logic cts;} modem_t;
	typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_BITS = 4'b0100,
		RX_STOP = 4'b1000} rx_state_t;
	typedef enum logic [3:0] {TX_IDLE = 4'b0001, TX_START = 4'b0010, TX_BITS = 4'b0100,
		TX_STOP = 4'b1000} tx_state_t;
	typedef struct packed {logic [1:0][7:0] mem; logic wp; logic rp; logic [1:0] cnt;} skid_state_t;

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic [3:0] wordLen(input logic [7:0] line_format_control);
		wordLen = BASE_WORD + {2'b00, line_format_control[1:0]};
	endfunction: wordLen

	function automatic logic parityBit(input logic [7:0] data, input logic [7:0] line_format_control);
		logic [7:0] m;
		m = data & (8'hFF >> (4'h8 - wordLen(line_format_control)));
		if (line_format_control[LCR_STICK])
			parityBit = !line_format_control[LCR_EPS];
		else
			parityBit = line_format_control[LCR_EPS] ? ^m : !(^m);
	endfunction: parityBit

endpackage: serial_channel_pkg

// ---- design/tx_skid_buffer.sv ----
// Two-entry byte buffer between transmit FIFO and shifter
// Assumes flush has priority over both sides
`timescale 1ns/1ns
module tx_skid_buffer
	import serial_channel_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       flush,
	input  wire logic       inValid,
	input  wire logic [7:0] inData,
	output logic            inReady,
	output logic            outValid,
	output logic [7:0]      outData,
	input  wire logic       outReady
);
	skid_state_t st;
	skid_state_t nx;
	logic        push;
	logic        pop;

	assign inReady  = st.cnt != BUF_DEPTH;
	assign outValid = st.cnt != 2'h0;
	assign outData  = st.mem[st.rp];

	always_comb
	begin
		nx   = st;
		push = inValid && inReady;
		pop  = outValid && outReady;
		if (flush)
		begin
			nx.wp  = 1'b0;
			nx.rp  = 1'b0;
			nx.cnt = 2'h0;
		end
		else
		begin
			if (push)
			begin
				nx.mem[st.wp] = inData;
				nx.wp = !st.wp;
			end
			if (pop)
				nx.rp = !st.rp;
			nx.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= nx;
	end
endmodule: tx_skid_buffer

// ---- design/serial_channel.sv ----
// One serial channel: register map, FIFOs, FIFO control, shifters
// Assumes one-cycle host strobes synchronous to clock; read data valid next cycle
`timescale 1ns/1ns
module serial_channel
	import serial_channel_pkg::*;
(
	input  wire logic     clock,
	input  wire logic     nrst,
	input  wire reg_req_t regReq,
	output logic [7:0]    regRdData,
	input  wire logic     serialIn,
	input  wire modem_t   modemIn,
	output logic          serialOut,
	output logic          termReady,
	output logic          reqToSend,
	output logic          spareOutput,
	output logic          irqPinGate,
	output logic          channelIrq,
	output logic          receiveReadyPinN,
	output logic          transmitReadyPinN
);
	typedef struct packed {
		logic [7:0]             line_format_control;
		logic [3:0]             interrupt_enable;
		logic [4:0]             modem_output_control;
		logic [7:0]             scratch_byte;
		logic [7:0]             dll;
		logic [7:0]             divisor_high_byte;
		logic                   fifoOn;
		logic                   readyMode;
		logic [1:0]             rxTrig;
		logic [15:0][7:0]       rxMem;
		logic [3:0]             rxWp;
		logic [3:0]             rxRp;
		logic [4:0]             rxCnt;
		logic [15:0][7:0]       txMem;
		logic [3:0]             txWp;
		logic [3:0]             txRp;
		logic [4:0]             txCnt;
		logic                   oe;
		logic                   pe;
		logic                   fe;
		logic                   bi;
		logic                   fifoErr;
		logic                   threIrq;
		logic                   prevThre;
		logic [3:0]             msrDelta;
		modem_t                 modemPrev;
		logic [15:0]            baudCnt;
		rx_state_t              rxState;
		logic [3:0]             rxTick;
		logic [3:0]             rxBit;
		logic [7:0]             rxShift;
		logic                   rxPar;
		tx_state_t              txState;
		logic [3:0]             txTick;
		logic [3:0]             txBit;
		logic [7:0]             txShift;
		logic                   txLine;
		logic [7:0]             rdData;
		logic                   sout;
		logic                   irq;
		logic                   rxRdyN;
		logic                   txRdyN;
	} chan_state_t;

	chan_state_t st;
	chan_state_t nx;
	logic        divisor_latch_select;
	logic        fcrWrite;
	logic        fcrToggle;
	logic        rxFlush;
	logic        txFlush;
	logic        baudTick;
	logic        rxLine;
	modem_t      modemNow;
	logic [4:0]  depth;
	logic [4:0]  trigLevel;
	logic        tx_holding_empty_flag;
	logic        transmitter_idle_flag;
	logic        bufReady;
	logic        bufValid;
	logic [7:0]  bufData;
	logic        irqPending;
	logic [3:0]  iid;
	logic        rxPush;
	logic        rxPop;
	logic        txPush;
	logic        txPop;
	logic        rxEnd;
	logic        txEnd;
	logic [3:0]  frameBits;
	logic [3:0]  nextBit;

	// ************************************************
	// Register decode
	// ************************************************
	assign divisor_latch_select = st.line_format_control[LCR_DIVISOR_LATCH_SELECT];
	assign fcrWrite = regReq.wr && regReq.addr == OFF_IIR;
	assign fcrToggle = fcrWrite && regReq.data[FCR_EN] != st.fifoOn;
	assign rxFlush = fcrToggle || (fcrWrite && regReq.data[FCR_EN] && regReq.data[FCR_RXCLR]);
	assign txFlush = fcrToggle || (fcrWrite && regReq.data[FCR_EN] && regReq.data[FCR_TXCLR]);

	// ************************************************
	// Loopback and line status terms
	// ************************************************
	assign modemNow = st.modem_output_control[MCR_LOOP] ? modem_t'{dcd: st.modem_output_control[MCR_IRQ_PIN_GATE], ri: st.modem_output_control[MCR_SPARE_OUTPUT],
		dsr: st.modem_output_control[MCR_DTR], cts: st.modem_output_control[MCR_RTS]} : modemIn;
	assign rxLine    = st.modem_output_control[MCR_LOOP] ? st.txLine : serialIn;
	assign baudTick  = {st.divisor_high_byte, st.dll} != 16'h0000 && st.baudCnt <= 16'h0001;
	assign depth     = st.fifoOn ? FIFO_FULL : ONE_DEEP;
	assign tx_holding_empty_flag      = st.txCnt == 5'h00 && !bufValid;
	assign transmitter_idle_flag      = tx_holding_empty_flag && st.txState == TX_IDLE;
	assign frameBits = wordLen(st.line_format_control) + {3'b000, st.line_format_control[LCR_PEN]};
	assign nextBit   = st.txBit + 4'h1;
	assign rxEnd     = baudTick && st.rxTick == LAST_TICK;
	assign txEnd     = baudTick && st.txTick == LAST_TICK;
	assign rxPush    = rxEnd && st.rxState == RX_STOP;
	assign rxPop     = regReq.rd && regReq.addr == OFF_DATA && !divisor_latch_select && st.rxCnt != 5'h00;
	assign txPush    = regReq.wr && regReq.addr == OFF_DATA && !divisor_latch_select && st.txCnt != depth;
	assign txPop     = st.txCnt != 5'h00 && bufReady && !txFlush;

	always_comb
	begin
		unique case (st.rxTrig)
			2'b00: trigLevel = TRIG_L0;
			2'b01: trigLevel = TRIG_L1;
			2'b10: trigLevel = TRIG_L2;
			2'b11: trigLevel = TRIG_L3;
		endcase
	end

	// ************************************************
	// Interrupt identification
	// ************************************************
	always_comb
	begin
		if (st.interrupt_enable[IER_LS] && (st.oe || st.pe || st.fe || st.bi))
			iid = IID_LINE;
		else if (st.interrupt_enable[IER_RX] && (st.fifoOn ? st.rxCnt >= trigLevel : st.rxCnt != 5'h00))
			iid = IID_RXD;
		else if (st.interrupt_enable[IER_TX] && st.threIrq)
			iid = IID_TX_HOLDING_EMPTY_FLAG;
		else if (st.interrupt_enable[IER_MS] && st.msrDelta != 4'h0)
			iid = IID_MDM;
		else
			iid = IID_NONE;
	end
	assign irqPending = iid != IID_NONE;

	tx_skid_buffer u_buf (
		.clock   (clock),
		.nrst    (nrst),
		.flush   (txFlush),
		.inValid (st.txCnt != 5'h00 && !txFlush),
		.inData  (st.txMem[st.txRp]),
		.inReady (bufReady),
		.outValid(bufValid),
		.outData (bufData),
		.outReady(st.txState == TX_IDLE)
	);

	// ************************************************
	// Next state
	// ************************************************
	always_comb
	begin
		nx = st;
		if ({st.divisor_high_byte, st.dll} == 16'h0000)
			nx.baudCnt = 16'h0000;
		else if (baudTick)
			nx.baudCnt = {st.divisor_high_byte, st.dll};
		else
			nx.baudCnt = st.baudCnt - 16'h0001;

		if (regReq.wr)
		begin
			unique case (regReq.addr)
				OFF_DATA: if (divisor_latch_select) nx.dll = regReq.data;
				OFF_IER:
				begin
					if (divisor_latch_select)
						nx.divisor_high_byte = regReq.data;
					else
						nx.interrupt_enable = regReq.data[3:0];
				end
				OFF_IIR:
				begin
					nx.fifoOn = regReq.data[FCR_EN];
					if (regReq.data[FCR_EN])
					begin
						nx.readyMode = regReq.data[FCR_MODE];
						nx.rxTrig    = regReq.data[FCR_TRIG+:2];
					end
				end
				OFF_LCR: nx.line_format_control = regReq.data;
				OFF_MCR: nx.modem_output_control = regReq.data[4:0];
				OFF_SCR: nx.scratch_byte = regReq.data;
				default: ;
			endcase
		end

		// Receive FIFO
		if (rxFlush)
		begin
			nx.rxWp  = 4'h0;
			nx.rxRp  = 4'h0;
			nx.rxCnt = 5'h00;
		end
		else
		begin
			if (rxPush && st.rxCnt != depth)
			begin
				nx.rxMem[st.rxWp] = st.rxShift;
				nx.rxWp = st.rxWp + 4'h1;
			end
			if (rxPop)
				nx.rxRp = st.rxRp + 4'h1;
			nx.rxCnt = st.rxCnt + {4'h0, rxPush && st.rxCnt != depth} - {4'h0, rxPop};
		end

		// Transmit FIFO
		if (txFlush)
		begin
			nx.txWp  = 4'h0;
			nx.txRp  = 4'h0;
			nx.txCnt = 5'h00;
		end
		else
		begin
			if (txPush)
			begin
				nx.txMem[st.txWp] = regReq.data;
				nx.txWp = st.txWp + 4'h1;
			end
			if (txPop)
				nx.txRp = st.txRp + 4'h1;
			nx.txCnt = st.txCnt + {4'h0, txPush} - {4'h0, txPop};
		end

		// status flags, set wins over read clear
		if (regReq.rd && regReq.addr == OFF_LSR)
		begin
			nx.oe = 1'b0;
			nx.pe = 1'b0;
			nx.fe = 1'b0;
			nx.bi = 1'b0;
			nx.fifoErr = 1'b0;
		end
		if (rxPush)
		begin
			if (st.rxCnt == depth)
				nx.oe = 1'b1;
			if (st.line_format_control[LCR_PEN] && st.rxPar != parityBit(st.rxShift, st.line_format_control))
				nx.pe = 1'b1;
			if (!rxLine)
				nx.fe = 1'b1;
			if (!rxLine && st.rxShift == 8'h00 && !(st.line_format_control[LCR_PEN] && st.rxPar))
				nx.bi = 1'b1;
			if (st.fifoOn && (!rxLine || (st.line_format_control[LCR_PEN] && st.rxPar != parityBit(st.rxShift, st.line_format_control))))
				nx.fifoErr = 1'b1;
		end

		// Holding-empty interrupt source
		nx.prevThre = tx_holding_empty_flag;
		if (txPush || (regReq.rd && regReq.addr == OFF_IIR && iid == IID_TX_HOLDING_EMPTY_FLAG))
			nx.threIrq = 1'b0;
		if ((tx_holding_empty_flag && !st.prevThre) || fcrToggle)
			nx.threIrq = 1'b1;

		// modem deltas, set wins over read clear
		nx.modemPrev = modemNow;
		if (regReq.rd && regReq.addr == OFF_MSR)
			nx.msrDelta = 4'h0;
		nx.msrDelta = nx.msrDelta | {modemNow.dcd != st.modemPrev.dcd,
			st.modemPrev.ri && !modemNow.ri, modemNow.dsr != st.modemPrev.dsr,
			modemNow.cts != st.modemPrev.cts};

		if (baudTick && st.rxState != RX_IDLE)
			nx.rxTick = st.rxTick + 4'h1;
		unique case (st.rxState)
			RX_IDLE:
			begin
				if (!rxLine)
				begin
					nx.rxState = RX_START;
					nx.rxTick  = 4'h0;
					nx.rxShift = 8'h00;
				end
			end
			RX_START:
			begin
				if (baudTick && st.rxTick == HALF_TICK)
				begin
					nx.rxState = rxLine ? RX_IDLE : RX_BITS;
					nx.rxTick  = 4'h0;
					nx.rxBit   = 4'h0;
				end
			end
			RX_BITS:
			begin
				if (rxEnd)
				begin
					if (st.rxBit < wordLen(st.line_format_control))
						nx.rxShift[st.rxBit[2:0]] = rxLine;
					else
						nx.rxPar = rxLine;
					nx.rxBit = st.rxBit + 4'h1;
					if (st.rxBit + 4'h1 == frameBits)
						nx.rxState = RX_STOP;
				end
			end
			RX_STOP:
			begin
				if (rxEnd)
					nx.rxState = RX_IDLE;
			end
			default: nx.rxState = RX_IDLE;
		endcase

		if (baudTick && st.txState != TX_IDLE)
			nx.txTick = st.txTick + 4'h1;
		unique case (st.txState)
			TX_IDLE:
			begin
				if (bufValid)
				begin
					nx.txShift = bufData;
					nx.txState = TX_START;
					nx.txTick  = 4'h0;
					nx.txLine  = 1'b0;
				end
			end
			TX_START:
			begin
				if (txEnd)
				begin
					nx.txState = TX_BITS;
					nx.txBit   = 4'h0;
					nx.txLine  = st.txShift[0];
				end
			end
			TX_BITS:
			begin
				if (txEnd && nextBit < frameBits)
				begin
					nx.txBit  = nextBit;
					nx.txLine = nextBit < wordLen(st.line_format_control) ? st.txShift[nextBit[2:0]] :
						parityBit(st.txShift, st.line_format_control);
				end
				else if (txEnd)
				begin
					nx.txState = TX_STOP;
					nx.txBit   = 4'h0;
					nx.txLine  = 1'b1;
				end
			end
			TX_STOP:
			begin
				if (txEnd && st.txBit == {3'b000, st.line_format_control[LCR_STB]})
					nx.txState = TX_IDLE;
				else if (txEnd)
					nx.txBit = nextBit;
			end
			default: nx.txState = TX_IDLE;
		endcase
		nx.sout = st.modem_output_control[MCR_LOOP] ? 1'b1 : (st.line_format_control[LCR_BRK] ? 1'b0 : nx.txLine);

		nx.irq = st.modem_output_control[MCR_IRQ_PIN_GATE] && irqPending;

		if (st.fifoOn && st.readyMode)
		begin
			nx.rxRdyN = !(st.rxCnt >= trigLevel);
			nx.txRdyN = st.txCnt == depth;
		end
		else
		begin
			nx.rxRdyN = st.rxCnt == 5'h00;
			nx.txRdyN = !tx_holding_empty_flag;
		end

		// Register read data
		if (regReq.rd)
		begin
			unique case (regReq.addr)
				OFF_DATA: nx.rdData = divisor_latch_select ? st.dll : st.rxMem[st.rxRp];
				OFF_IER: nx.rdData = divisor_latch_select ? st.divisor_high_byte : {4'h0, st.interrupt_enable};
				OFF_IIR: nx.rdData = {st.fifoOn, st.fifoOn, 2'b00, iid[3] & st.fifoOn, iid[2:1], !irqPending};
				OFF_LCR: nx.rdData = st.line_format_control;
				OFF_MCR: nx.rdData = {3'b000, st.modem_output_control};
				OFF_LSR: nx.rdData = {st.fifoOn & st.fifoErr, transmitter_idle_flag, tx_holding_empty_flag, st.bi, st.fe, st.pe, st.oe,
					st.rxCnt != 5'h00};
				OFF_MSR: nx.rdData = {modemNow, st.msrDelta};
				OFF_SCR: nx.rdData = st.scratch_byte;
				default: nx.rdData = RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			st         <= '0;
			st.rxState <= RX_IDLE;
			st.txState <= TX_IDLE;
			st.txLine  <= 1'b1;
			st.sout    <= 1'b1;
			st.rxRdyN  <= 1'b1;
			st.txRdyN  <= 1'b1;
		end
		else
			st <= nx;
	end

	assign regRdData         = st.rdData;
	assign serialOut         = st.sout;
	assign termReady         = st.modem_output_control[MCR_DTR];
	assign reqToSend         = st.modem_output_control[MCR_RTS];
	assign spareOutput       = st.modem_output_control[MCR_SPARE_OUTPUT];
	assign irqPinGate        = st.modem_output_control[MCR_IRQ_PIN_GATE];
	assign channelIrq        = st.irq;
	assign receiveReadyPinN  = st.rxRdyN;
	assign transmitReadyPinN = st.txRdyN;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_fcrOn;
		fcrWrite && regReq.data[FCR_EN];
	endsequence
	sequence s_fcrOff;
		fcrWrite && !regReq.data[FCR_EN];
	endsequence

	property p_fcrEnable;
		fcrWrite |=> st.fifoOn == $past(regReq.data[FCR_EN]);
	endproperty
	a_fcrEnable: assert property (p_fcrEnable) else $error("fifo enable not taken");
	property p_toggleFlush;
		fcrToggle |=> st.rxCnt == 5'h00 && st.txCnt == 5'h00 && !bufValid;
	endproperty
	a_toggleFlush: assert property (p_toggleFlush) else $error("toggle did not flush");
	property p_offHolds;
		s_fcrOff |=> $stable(st.rxTrig) && $stable(st.readyMode);
	endproperty
	a_offHolds: assert property (p_offHolds) else $error("control changed while disabled");
	property p_rxClear;
		s_fcrOn ##0 regReq.data[FCR_RXCLR] |=> st.rxCnt == 5'h00;
	endproperty
	a_rxClear: assert property (p_rxClear) else $error("receive fifo not cleared");
	property p_trig;
		s_fcrOn |=> st.rxTrig == $past(regReq.data[7:6]);
	endproperty
	a_trig: assert property (p_trig) else $error("trigger field not taken");
	property p_iirOff;
		regReq.rd && regReq.addr == OFF_IIR && !st.fifoOn |=> regRdData[7:6] == 2'b00 && !regRdData[3];
	endproperty
	a_iirOff: assert property (p_iirOff) else $error("fifo bits set while disabled");
	property p_iirPending;
		regReq.rd && regReq.addr == OFF_IIR |=> regRdData[0] == !$past(irqPending);
	endproperty
	a_iirPending: assert property (p_iirPending) else $error("pending bit wrong");
	property p_ierHigh;
		regReq.rd && regReq.addr == OFF_IER && !divisor_latch_select |=> regRdData[7:4] == 4'h0;
	endproperty
	a_ierHigh: assert property (p_ierHigh) else $error("enable upper bits not zero");
	property p_dlabRead;
		regReq.rd && regReq.addr == OFF_DATA && divisor_latch_select |=> regRdData == $past(st.dll);
	endproperty
	a_dlabRead: assert property (p_dlabRead) else $error("divisor low byte not read");
	property p_lsrThre;
		regReq.rd && regReq.addr == OFF_LSR |=> regRdData[5] == $past(tx_holding_empty_flag);
	endproperty
	a_lsrThre: assert property (p_lsrThre) else $error("holding empty flag wrong");
	property p_mode0Pin;
		!(st.fifoOn && st.readyMode) |=> receiveReadyPinN == ($past(st.rxCnt) == 5'h00);
	endproperty
	a_mode0Pin: assert property (p_mode0Pin) else $error("receive ready mode 0 wrong");
endmodule: serial_channel

// ---- tb/serial_far_end.sv ----
// Far-end model: drives the receive line and the modem input levels
// Assumes divisor 1, so one bit lasts 16 clocks
`timescale 1ns/1ns
module serial_far_end
	import serial_channel_pkg::*;
(
	input  wire logic clock,
	input  wire logic serialOut,
	output logic      serialIn,
	output modem_t    modemIn
);
	// ************************************************
	// Line driver
	// ************************************************
	initial
	begin
		serialIn = 1'b1;
		modemIn  = '0;
	end

	task automatic sendByte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clock) serialIn <= frame[i];
			repeat (15) @(posedge clock);
		end
	endtask: sendByte

	task automatic setModem(input modem_t m);
		@(posedge clock) modemIn <= m;
	endtask: setModem
endmodule: serial_far_end

// ---- tb/test_serial_channel.sv ----
// Self-checking bench for one serial channel
// Assumes the far-end model in serial_far_end.sv
`timescale 1ns/1ns
module test_serial_channel
	import serial_channel_pkg::*;
;
	logic       clock;
	logic       nrst;
	reg_req_t   regReq;
	logic [7:0] regRdData;
	logic       serialIn;
	modem_t     modemIn;
	logic       serialOut;
	logic       termReady;
	logic       reqToSend;
	logic       spareOutput;
	logic       irqPinGate;
	logic       channelIrq;
	logic       receiveReadyPinN;
	logic       transmitReadyPinN;
	int         err_total;
	int         n_compared;
	logic [7:0] rdVal;

	serial_channel serial_channel_i (.clock(clock), .nrst(nrst), .regReq(regReq), .regRdData(regRdData),
		.serialIn(serialIn), .modemIn(modemIn), .serialOut(serialOut), .termReady(termReady),
		.reqToSend(reqToSend), .spareOutput(spareOutput), .irqPinGate(irqPinGate), .channelIrq(channelIrq),
		.receiveReadyPinN(receiveReadyPinN), .transmitReadyPinN(transmitReadyPinN));
	serial_far_end serial_far_end_i (.clock(clock), .serialOut(serialOut), .serialIn(serialIn),
		.modemIn(modemIn));

	// ************************************************
	// Access tasks
	// ************************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask: check

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock) regReq <= '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
		@(posedge clock) regReq.wr <= 1'b0;
	endtask: wr

	task automatic rdChk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge clock) regReq <= '{rd: 1'b1, wr: 1'b0, addr: a, data: 8'h00};
		@(posedge clock) regReq.rd <= 1'b0;
		#1 rdVal = regRdData;
		check(rdVal & m, exp);
	endtask: rdChk

	task automatic finish_test();
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask: finish_test

	// ************************************************
	// Clock and watchdog
	// ************************************************
	always #2 clock = ~clock;

	initial
	begin
		#100000;
		err_total++;
		finish_test();
	end

	// ************************************************
	// Scenarios
	// ************************************************
	initial
	begin
		clock = 1'b0;
		nrst = 1'b0;
		regReq = '0;
		err_total = 0;
		n_compared = 0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		rdChk(OFF_IIR, 8'hFF, 8'h01);
		rdChk(OFF_LSR, 8'hFF, 8'h60);
		wr(OFF_SCR, 8'hA5);
		rdChk(OFF_SCR, 8'hFF, 8'hA5);
		wr(OFF_IER, 8'hF2);
		rdChk(OFF_IER, 8'hFF, 8'h02);
		wr(OFF_LCR, 8'h3F);
		rdChk(OFF_LCR, 8'hFF, 8'h3F);
		wr(OFF_MCR, 8'hEF);
		rdChk(OFF_MCR, 8'hFF, 8'h0F);
		check({4'h0, irqPinGate, spareOutput, reqToSend, termReady}, 8'h0F);
		wr(OFF_LCR, 8'h80);
		wr(OFF_DATA, 8'h01);
		wr(OFF_IER, 8'h00);
		rdChk(OFF_DATA, 8'hFF, 8'h01);
		wr(OFF_LCR, 8'h03);
		rdChk(OFF_IER, 8'hFF, 8'h02);
		serial_far_end_i.setModem(4'h1);
		repeat (3) @(posedge clock);
		rdChk(OFF_MSR, 8'hFF, 8'h11);
		rdChk(OFF_MSR, 8'hFF, 8'h10);
		wr(OFF_IIR, 8'h41);
		wr(OFF_IER, 8'h01);
		rdChk(OFF_IIR, 8'hFF, 8'hC1);
		serial_far_end_i.sendByte(8'h1E);
		serial_far_end_i.sendByte(8'h2D);
		serial_far_end_i.sendByte(8'h3C);
		repeat (20) @(posedge clock);
		rdChk(OFF_IIR, 8'hFF, 8'hC1);
		serial_far_end_i.sendByte(8'h4B);
		repeat (20) @(posedge clock);
		rdChk(OFF_IIR, 8'hFF, 8'hC4);
		check({7'h0, channelIrq}, 8'h01);
		check({7'h0, receiveReadyPinN}, 8'h00);
		rdChk(OFF_DATA, 8'hFF, 8'h1E);
		wr(OFF_IIR, 8'h43);
		rdChk(OFF_LSR, 8'h01, 8'h00);
		wr(OFF_LCR, 8'h80);
		wr(OFF_DATA, 8'h00);
		wr(OFF_LCR, 8'h03);
		wr(OFF_IIR, 8'h09);
		for (int i = 0; i < 20; i++)
			wr(OFF_DATA, 8'(i));
		repeat (4) @(posedge clock);
		#1;
		check({7'h0, transmitReadyPinN}, 8'h01);
		wr(OFF_IIR, 8'h0D);
		repeat (3) @(posedge clock);
		#1;
		check({7'h0, transmitReadyPinN}, 8'h00);
		check({7'h0, serialOut}, 8'h00);
		rdChk(OFF_LSR, 8'h60, 8'h20);
		wr(OFF_IIR, 8'h00);
		rdChk(OFF_LSR, 8'hA0, 8'h20);
		rdChk(OFF_IIR, 8'hC8, 8'h00);
		finish_test();
	end
endmodule: test_serial_channel
